// [rtl/iowd_pkg.sv]
package iowd_pkg;
  // ************************************************************
  // Register map (I/O port addresses)
  // ************************************************************
  localparam logic [11:0] ADDR_UNIT_SEL = 12'h865;
  localparam logic [11:0] ADDR_TIMEOUT_VAL = 12'h866;
  localparam logic [11:0] ADDR_FINISH_LOW = 12'h867;
  localparam logic [11:0] ADDR_FINISH_HIGH = 12'h868;

  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam int UNIT_SEC_BIT = 7;
  localparam logic [7:0] UNIT_SEL_RESET = 8'h00;
  localparam logic [7:0] TIMEOUT_VAL_RESET = 8'h00;
  localparam logic [7:0] FINISH_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int STATUS_BIT = 0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYCLES = SECOND_S * CLK_HZ;
  localparam int MINUTE_S = 60;
  localparam int SECONDS_PER_MINUTE = MINUTE_S / SECOND_S;

  typedef enum logic [1:0] {
    IOWD_IDLE = 2'b00,
    IOWD_RUN = 2'b01,
    IOWD_EXPIRED = 2'b10
  } iowd_state_e;
endpackage

// [rtl/iowd_tick_gen.sv]
`timescale 1ns/1ns
// Produces one-cycle second ticks and minute ticks while enabled
module iowd_tick_gen
  import iowd_pkg::*;
#(
  parameter int SEC_CYCLES = SECOND_CYCLES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_restart,
  input wire logic i_run,
  // Ticks
  output logic o_sec_tick,
  output logic o_min_tick
);
  logic [23:0] cyc_reg;
  logic [5:0] sec_reg;
  wire cyc_last = (cyc_reg == 24'(SEC_CYCLES - 1));
  wire sec_last = (sec_reg == 6'(SECONDS_PER_MINUTE - 1));

  // Prescaler restarts on every reload so the first unit is full length
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_reg <= 24'h000000;
      sec_reg <= 6'h00;
    end else if (i_restart || !i_run) begin
      cyc_reg <= 24'h000000;
      sec_reg <= 6'h00;
    end else if (cyc_last) begin
      cyc_reg <= 24'h000000;
      sec_reg <= sec_last ? 6'h00 : sec_reg + 6'h01;
    end else begin
      cyc_reg <= cyc_reg + 24'h000001;
    end
  end

  assign o_sec_tick = i_run && !i_restart && cyc_last;
  assign o_min_tick = o_sec_tick && sec_last;
endmodule

// [rtl/iowd_top.sv]
`timescale 1ns/1ns
module iowd_top
  import iowd_pkg::*;
#(
  parameter int SEC_CYCLES = SECOND_CYCLES
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // I/O port bus
  input wire logic [11:0] I_IO_ADDR,
  input wire logic [7:0] I_IO_WDATA,
  input wire logic I_IO_WR,
  input wire logic I_IO_RD,
  output logic [7:0] O_IO_RDATA,
  // Watchdog status
  output logic O_TIMEOUT,
  output logic O_RUNNING
);
  // ************************************************************
  // Reset release
  // ************************************************************
  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  wire wr_unit = I_IO_WR && hit(I_IO_ADDR, ADDR_UNIT_SEL);
  wire wr_val = I_IO_WR && hit(I_IO_ADDR, ADDR_TIMEOUT_VAL);
  wire wr_low = I_IO_WR && hit(I_IO_ADDR, ADDR_FINISH_LOW);
  wire wr_high = I_IO_WR && hit(I_IO_ADDR, ADDR_FINISH_HIGH);
  wire wr_zero = (I_IO_WDATA == ZERO_BYTE);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] unit_reg;
  logic [7:0] val_reg;
  logic [7:0] low_reg;
  logic [7:0] high_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic status_reg;
  logic status_next;
  iowd_state_e state_reg;
  iowd_state_e state_next;
  logic [7:0] rdata_reg;

  // Software-written storage; finish registers hold their byte, and a zero write to the high one also clears the status flag
  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      unit_reg <= UNIT_SEL_RESET;
      val_reg <= TIMEOUT_VAL_RESET;
      low_reg <= FINISH_RESET;
      high_reg <= FINISH_RESET;
    end else begin
      if (wr_unit) unit_reg <= I_IO_WDATA;
      if (wr_val) val_reg <= I_IO_WDATA;
      if (wr_low) low_reg <= I_IO_WDATA;
      if (wr_high) high_reg <= I_IO_WDATA;
    end
  end

  // ************************************************************
  // Unit ticks
  // ************************************************************
  logic sec_tick;
  logic min_tick;
  wire running = (state_reg == IOWD_RUN);
  wire unit_tick = unit_reg[UNIT_SEC_BIT] ? sec_tick : min_tick;

  iowd_tick_gen #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_tick (
    .i_clk(I_CORE_CLK),
    .i_rst_n(rst_n),
    .i_restart(wr_val),
    .i_run(running),
    .o_sec_tick(sec_tick),
    .o_min_tick(min_tick)
  );

  // ************************************************************
  // Countdown state machine
  // ************************************************************
  // A value write always wins over a tick in the same cycle
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      IOWD_IDLE: begin
        if (wr_val && !wr_zero) begin
          state_next = IOWD_RUN;
          count_next = I_IO_WDATA;
        end
      end
      IOWD_RUN: begin
        if (wr_val && wr_zero) begin
          state_next = IOWD_IDLE;
          count_next = ZERO_BYTE;
        end else if (wr_val) begin
          count_next = I_IO_WDATA;
        end else if (unit_tick) begin
          count_next = count_reg - 8'h01;
          if (count_reg == 8'h01) begin
            state_next = IOWD_EXPIRED;
          end
        end
      end
      IOWD_EXPIRED: begin
        if (wr_val && wr_zero) begin
          state_next = IOWD_IDLE;
        end else if (wr_val) begin
          state_next = IOWD_RUN;
          count_next = I_IO_WDATA;
        end
      end
      default: begin
        state_next = IOWD_IDLE;
        count_next = ZERO_BYTE;
      end
    endcase
  end

  // Expiry sets the flag; the set wins over a same-cycle clear
  wire expire_now = running && !wr_val && unit_tick && (count_reg == 8'h01);
  wire clear_status = wr_high && wr_zero;
  assign status_next = expire_now ? 1'b1 : (clear_status ? 1'b0 : status_reg);

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= IOWD_IDLE;
      count_reg <= ZERO_BYTE;
      status_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      status_reg <= status_next;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  // High register shows the status flag in bit 0 and the stored byte in bits 7:1
  wire [7:0] high_view = {high_reg[7:1], status_reg};
  wire [7:0] rd_mux = hit(I_IO_ADDR, ADDR_UNIT_SEL) ? unit_reg :
                      hit(I_IO_ADDR, ADDR_TIMEOUT_VAL) ? count_reg :
                      hit(I_IO_ADDR, ADDR_FINISH_LOW) ? low_reg :
                      hit(I_IO_ADDR, ADDR_FINISH_HIGH) ? high_view : ZERO_BYTE;

  always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= ZERO_BYTE;
    end else if (I_IO_RD) begin
      rdata_reg <= rd_mux;
    end
  end

  assign O_IO_RDATA = rdata_reg;
  assign O_TIMEOUT = status_reg;
  assign O_RUNNING = running;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_load_nonzero;
    wr_val && !wr_zero;
  endsequence

  a_load_starts_run: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    s_load_nonzero |=> running && count_reg == $past(I_IO_WDATA))
    else $error("non-zero write did not start countdown");
  a_zero_stops: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    wr_val && wr_zero |=> !running && count_reg == ZERO_BYTE)
    else $error("zero write did not stop watchdog");
  a_expired_holds: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    state_reg == IOWD_EXPIRED && !wr_val |=> state_reg == IOWD_EXPIRED)
    else $error("expired watchdog left its state without a write");
  a_idle_holds: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    !running && !wr_val |=> $stable(count_reg))
    else $error("count moved while disabled");
  a_unit_minute: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    running && !wr_val && !unit_reg[UNIT_SEC_BIT] && !min_tick |=> $stable(count_reg))
    else $error("minute mode decremented without minute tick");
  a_unit_second: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    running && !wr_val && unit_reg[UNIT_SEC_BIT] && sec_tick && count_reg > 8'h01
    |=> count_reg == $past(count_reg) - 8'h01)
    else $error("second tick did not decrement");
  a_count_range: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    running |-> count_reg != ZERO_BYTE)
    else $error("running count left 1..255");
  a_expire_flag: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    expire_now |=> O_TIMEOUT && state_reg == IOWD_EXPIRED)
    else $error("expiry did not raise timeout");
  a_flag_clear: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    clear_status && !expire_now |=> !O_TIMEOUT)
    else $error("status not cleared by high register");
  a_flag_holds: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    !expire_now && !clear_status |=> $stable(O_TIMEOUT))
    else $error("status flag moved without expiry or clear");
  a_finish_store: assert property (@(posedge I_CORE_CLK) disable iff (!rst_n)
    wr_low |=> low_reg == $past(I_IO_WDATA))
    else $error("finish low register not stored");
endmodule

// [verification/tb.sv]
`timescale 1ns/1ns
module tb;
  import iowd_pkg::*;
  // ****************************************
  // Signals and design
  // ****************************************
  localparam int SC = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic tmo;
  logic run;
  logic [15:0] exp_q[$];
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n;
  int k;
  // Short second so that a full 255-unit count fits in the run
  always #50 clk = ~clk;
  iowd_top #(.SEC_CYCLES(SC)) DUT (.I_CORE_CLK(clk), .I_RSTN(rst_n), .I_IO_ADDR(addr),
    .I_IO_WDATA(wdata), .I_IO_WR(wr), .I_IO_RD(rd), .O_IO_RDATA(rdata),
    .O_TIMEOUT(tmo), .O_RUNNING(run));
  // ****************************************
  // Tasks; every task that waits for the clock starts and ends 1 ns after a rising edge
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
    compares++;
    if (seen !== expv) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic step(input int c);
    repeat (c) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
  endtask
  // The expectation is queued; the monitor below compares it
  task automatic rd_reg(input logic [11:0] a, input logic [7:0] expv);
    addr = a;
    rd = 1'b1;
    exp_q.push_back({8'h00, expv});
    step(1);
    rd = 1'b0;
  endtask
  // Counts cycles until the timeout flag shows, bounded
  task automatic wait_exp(output int i);
    i = 0;
    do begin
      step(1);
      i++;
    end while (tmo !== 1'b1 && i < 2000);
  endtask
  // Software finishing sequence, low then high
  task automatic finish_cfg;
    wr_reg(ADDR_FINISH_LOW, 8'h00);
    wr_reg(ADDR_FINISH_HIGH, 8'h00);
  endtask
  task automatic final_report;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Read data is registered, so it is settled just after the read edge
  always begin : mon
    logic rd_now;
    @(posedge clk);
    rd_now = rd;
    #2;
    if (rd_now === 1'b1) begin
      check("read data", {8'h00, rdata}, exp_q.pop_front());
    end
  end
  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h3FAF));
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(3);
    rd_reg(ADDR_UNIT_SEL, UNIT_SEL_RESET);
    rd_reg(ADDR_TIMEOUT_VAL, TIMEOUT_VAL_RESET);
    rd_reg(ADDR_FINISH_LOW, FINISH_RESET);
    rd_reg(ADDR_FINISH_HIGH, FINISH_RESET);
    rd_reg(12'h869, 8'h00);
    check("timeout", {15'h0, tmo}, 16'h0000);
    check("running", {15'h0, run}, 16'h0000);
    $display("test reset done");
    // Seconds unit: smallest, a random middle and the largest count
    wr_reg(ADDR_UNIT_SEL, 8'h80);
    rd_reg(ADDR_UNIT_SEL, 8'h80);
    for (int t = 0; t < 3; t++) begin
      n = (t == 0) ? 1 : (t == 1) ? $urandom_range(6, 2) : 255;
      wr_reg(ADDR_TIMEOUT_VAL, n[7:0]);
      check("running", {15'h0, run}, 16'h0001);
      rd_reg(ADDR_TIMEOUT_VAL, n[7:0]);
      wait_exp(k);
      // The read-back of the loaded value uses up the first cycle of the wait
      check("expiry cycles", k[15:0], 16'(n * SC - 1));
      check("running", {15'h0, run}, 16'h0000);
      rd_reg(ADDR_TIMEOUT_VAL, 8'h00);
      rd_reg(ADDR_FINISH_HIGH, 8'h01);
      finish_cfg();
      check("timeout", {15'h0, tmo}, 16'h0000);
      rd_reg(ADDR_FINISH_HIGH, 8'h00);
    end
    $display("test seconds done");
    // Zero write in mid-count stops everything
    wr_reg(ADDR_TIMEOUT_VAL, 8'h05);
    step(8);
    wr_reg(ADDR_TIMEOUT_VAL, 8'h00);
    check("running", {15'h0, run}, 16'h0000);
    rd_reg(ADDR_TIMEOUT_VAL, 8'h00);
    step(30);
    check("timeout", {15'h0, tmo}, 16'h0000);
    $display("test disable done");
    // A reload in mid-count restarts from the new value
    wr_reg(ADDR_TIMEOUT_VAL, 8'h03);
    step(10);
    wr_reg(ADDR_TIMEOUT_VAL, 8'h02);
    wait_exp(k);
    check("reload cycles", k[15:0], 16'(2 * SC));
    finish_cfg();
    $display("test reload done");
    // Minutes unit: one count lasts sixty seconds
    wr_reg(ADDR_UNIT_SEL, 8'h00);
    rd_reg(ADDR_UNIT_SEL, 8'h00);
    wr_reg(ADDR_TIMEOUT_VAL, 8'h01);
    wait_exp(k);
    check("minute cycles", k[15:0], 16'(SECONDS_PER_MINUTE * SC));
    wr_reg(ADDR_FINISH_HIGH, 8'hA4);
    check("timeout", {15'h0, tmo}, 16'h0001);
    rd_reg(ADDR_FINISH_HIGH, 8'hA5);
    wr_reg(ADDR_FINISH_LOW, 8'h5A);
    rd_reg(ADDR_FINISH_LOW, 8'h5A);
    finish_cfg();
    check("timeout", {15'h0, tmo}, 16'h0000);
    step(2);
    $display("test minutes done");
    final_report();
  end
endmodule
